// *** verilog/port_two.sv ***
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module port_two
  import port_two_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power mode from the system controller
  input wire power_mode_e power_mode,
  // serial interface side
  input wire logic ser_tx_data,
  output logic ser_rx_data,
  input wire logic ser_clk_out,
  output logic ser_clk_in,
  // pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe
);
  typedef struct packed {
    logic aw_held;
    logic [17:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] data_latch;
    logic [2:0] direction;
    logic tx_select;
    logic [3:0] serial_ctrl;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic rx_data;
    logic clk_in;
  } port_s;
  port_s st_r, st_nxt;

  pin_sync_bus sbus();
  logic [2:0] pin_level;

  assign sbus.raw = pin_in;
  assign pin_level = sbus.level;

  pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(sbus.sync)
  );

  // decoded register targets; only word-aligned addresses hit a register
  typedef enum logic [2:0] {
    SEL_DATA,
    SEL_DIR,
    SEL_MODE,
    SEL_CTRL,
    SEL_NONE
  } reg_sel_e;

  // the bus compares word indexes, so the two low address bits must be zero
  function automatic reg_sel_e decode_addr(input logic [17:0] a);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[17:2])
        DATA_LATCH_ADDR: begin
          sel = SEL_DATA;
        end
        DIRECTION_ADDR: begin
          sel = SEL_DIR;
        end
        PORT_MODE_SEVEN_ADDR: begin
          sel = SEL_MODE;
        end
        SERIAL_CTRL_ADDR: begin
          sel = SEL_CTRL;
        end
        default: begin
          sel = SEL_NONE;
        end
      endcase
    end
    return sel;
  endfunction

  // unmapped addresses answer with an error and change nothing
  function automatic logic [1:0] resp_for(input reg_sel_e sel);
    logic [1:0] resp;
    resp = RESP_OKAY;
    if (sel == SEL_NONE) begin
      resp = RESP_SLVERR;
    end
    return resp;
  endfunction

  // pin 0 becomes a clock output only while the external clock source is off
  function automatic logic clk_out_claim(input logic [3:0] ctrl);
    logic hi_off;
    logic lo_or_sync;
    hi_off = !ctrl[CTRL_CLK_HI_BIT];
    lo_or_sync = ctrl[CTRL_CLK_LO_BIT] || ctrl[CTRL_SYNC_BIT];
    return hi_off && lo_or_sync;
  endfunction

  function automatic logic clk_in_claim(input logic [3:0] ctrl);
    return ctrl[CTRL_CLK_HI_BIT];
  endfunction

  function automatic logic rx_claim(input logic [3:0] ctrl);
    return ctrl[CTRL_RX_ON_BIT];
  endfunction

  // output enables: direction first, then each serial claim overrides its own pin
  function automatic logic [2:0] drive_enable(
    input logic [2:0] dir,
    input logic tx_sel,
    input logic [3:0] ctrl
  );
    logic [2:0] en;
    en = dir;
    if (tx_sel) begin
      en[PIN_TX] = 1'b1;
    end
    if (rx_claim(ctrl)) begin
      en[PIN_RX] = 1'b0;
    end
    if (clk_in_claim(ctrl)) begin
      en[PIN_CLK] = 1'b0;
    end else if (clk_out_claim(ctrl)) begin
      en[PIN_CLK] = 1'b1;
    end
    return en;
  endfunction

  // output levels: latch first, then the serial outputs take their pins
  function automatic logic [2:0] drive_value(
    input logic [2:0] latch,
    input logic tx_sel,
    input logic [3:0] ctrl,
    input logic tx_data,
    input logic clk_out
  );
    logic [2:0] val;
    val = latch;
    if (tx_sel) begin
      val[PIN_TX] = tx_data;
    end
    if (clk_out_claim(ctrl)) begin
      val[PIN_CLK] = clk_out;
    end
    return val;
  endfunction

  // output pins read back their latch, input pins the filtered pin level
  function automatic logic [2:0] port_read(
    input logic [2:0] dir,
    input logic [2:0] latch,
    input logic [2:0] level
  );
    logic [2:0] val;
    val = level;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (dir[i]) begin
        val[i] = latch[i];
      end else begin
        val[i] = level[i];
      end
    end
    return val;
  endfunction

  // every register is one byte in the low lane; the rest of the word reads zero
  function automatic logic [31:0] read_word(
    input reg_sel_e sel,
    input logic [2:0] port_val,
    input logic tx_sel,
    input logic [3:0] ctrl
  );
    logic [31:0] word;
    word = 32'h0;
    unique case (sel)
      SEL_DATA: begin
        word = {29'h0, port_val};
      end
      SEL_DIR: begin
        word = {24'h0, DIRECTION_READ_VALUE};
      end
      SEL_MODE: begin
        word = {24'h0, MODE_SEVEN_RSVD_ONES, tx_sel, 2'h0};
      end
      SEL_CTRL: begin
        word = {28'h0, ctrl};
      end
      SEL_NONE: begin
        word = 32'h0;
      end
    endcase
    return word;
  endfunction

  reg_sel_e wr_sel, rd_sel;
  logic [2:0] drive_val, drive_en, gp_read;
  logic wr_go, rd_go;

  always_comb begin
    st_nxt = st_r;
    wr_sel = decode_addr(st_r.aw_addr);
    rd_sel = decode_addr(s_axi_araddr);
    drive_en = drive_enable(st_r.direction, st_r.tx_select, st_r.serial_ctrl);
    drive_val = drive_value(st_r.data_latch, st_r.tx_select, st_r.serial_ctrl, ser_tx_data, ser_clk_out);
    // pins freeze in PM_HOLD and float in PM_FLOAT; reset clears the registers, so they float then too
    unique case (power_mode)
      PM_ACTIVE: begin
        st_nxt.pin_out = drive_val;
        st_nxt.pin_oe = drive_en;
      end
      PM_HOLD: begin
      end
      PM_FLOAT: begin
        st_nxt.pin_out = 3'h0;
        st_nxt.pin_oe = 3'h0;
      end
    endcase
    // the serial block always sees the filtered levels and decides itself whether to use them
    st_nxt.rx_data = pin_level[PIN_RX];
    st_nxt.clk_in = pin_level[PIN_CLK];
    gp_read = port_read(st_r.direction, st_r.data_latch, pin_level);

    // write channel: address and data accepted in either order
    if (s_axi_awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = resp_for(wr_sel);
      // a write with lane 0 off is answered but changes nothing
      if (st_r.w_lane0) begin
        unique case (wr_sel)
          SEL_DATA: begin
            st_nxt.data_latch = st_r.w_data[2:0];
          end
          SEL_DIR: begin
            st_nxt.direction = st_r.w_data[2:0];
          end
          SEL_MODE: begin
            st_nxt.tx_select = st_r.w_data[MODE_SEVEN_TX_BIT];
          end
          SEL_CTRL: begin
            st_nxt.serial_ctrl = st_r.w_data[3:0];
          end
          SEL_NONE: begin
          end
        endcase
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    rd_go = s_axi_arvalid && !st_r.rvalid;
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = resp_for(rd_sel);
      st_nxt.rdata = read_word(rd_sel, gp_read, st_r.tx_select, st_r.serial_ctrl);
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.data_latch <= DATA_LATCH_RESET;
      st_r.direction <= DIRECTION_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = !st_r.aw_held;
  assign s_axi_wready = !st_r.w_held;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign pin_out = st_r.pin_out;
  assign pin_oe = st_r.pin_oe;
  assign ser_rx_data = st_r.rx_data;
  assign ser_clk_in = st_r.clk_in;
endmodule
`default_nettype wire

// *** verilog/port_two_pkg.sv ***
package port_two_pkg;
  localparam int PIN_COUNT = 3;
  localparam logic [15:0] DATA_LATCH_ADDR = 16'hFFD5;
  localparam logic [15:0] DIRECTION_ADDR = 16'hFFE5;
  localparam logic [15:0] PORT_MODE_SEVEN_ADDR = 16'hFFFF;
  localparam logic [15:0] SERIAL_CTRL_ADDR = 16'hFF00;
  // the offsets above are word indexes; the bus carries byte addresses, four times the index
  localparam logic [17:0] DATA_LATCH_BYTE = {DATA_LATCH_ADDR, 2'h0};
  localparam logic [17:0] DIRECTION_BYTE = {DIRECTION_ADDR, 2'h0};
  localparam logic [17:0] PORT_MODE_SEVEN_BYTE = {PORT_MODE_SEVEN_ADDR, 2'h0};
  localparam logic [17:0] SERIAL_CTRL_BYTE = {SERIAL_CTRL_ADDR, 2'h0};
  localparam logic [2:0] DATA_LATCH_RESET = 3'h0;
  localparam logic [2:0] DIRECTION_RESET = 3'h0;
  localparam logic [7:0] DIRECTION_READ_VALUE = 8'hFF;
  localparam logic [4:0] MODE_SEVEN_RSVD_ONES = 5'h1F;
  localparam int MODE_SEVEN_TX_BIT = 2;
  localparam int CTRL_RX_ON_BIT = 0;
  localparam int CTRL_CLK_LO_BIT = 1;
  localparam int CTRL_CLK_HI_BIT = 2;
  localparam int CTRL_SYNC_BIT = 3;
  localparam int PIN_TX = 2;
  localparam int PIN_RX = 1;
  localparam int PIN_CLK = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PM_ACTIVE, PM_HOLD, PM_FLOAT} power_mode_e;
endpackage

// *** verilog/pin_sync_bus.sv ***
`timescale 1ns/1ns
`default_nettype none
interface pin_sync_bus;
  logic [2:0] raw;
  logic [2:0] level;
  modport sync (input raw, output level);
  modport user (output raw, input level);
endinterface
`default_nettype wire

// *** verilog/pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_sync
  import port_two_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins in, filtered level out
  pin_sync_bus.sync bus
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] level;
  } sync_s;
  sync_s st_r, st_nxt;

  // a change counts only once stages two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = bus.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.level[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.level = st_r.level;
endmodule
`default_nettype wire

// *** testbench/port_two_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_two_chk
  import port_two_pkg::*;
(
  // clock and reset
  input wire logic aclk, aresetn,
  // register bus
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input wire logic [17:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // power and pins
  input wire power_mode_e power_mode,
  input wire logic [2:0] pin_out, pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  // the reset checks must run while reset is low, so they opt out of the default disable
  property p_rst_oe; disable iff (1'b0) !aresetn |=> pin_oe == 3'h0; endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("pins driven in reset");
  property p_rst_bus; disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready; endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus not idle after reset");
  property p_stby; power_mode == PM_FLOAT [*2] |-> pin_oe == 3'h0; endproperty
  a_stby: assert property (p_stby) else $error("pins driven in standby");
  property p_hold; $past(power_mode) == PM_HOLD && $past(aresetn) |-> $stable(pin_out) && $stable(pin_oe); endproperty
  a_hold: assert property (p_hold) else $error("pins moved in hold");
  property p_dir; ar_hs && s_axi_araddr == DIRECTION_BYTE |=> s_axi_rdata == {24'h0, DIRECTION_READ_VALUE}; endproperty
  a_dir: assert property (p_dir) else $error("direction read not all ones");
  property p_dat; ar_hs && s_axi_araddr == DATA_LATCH_BYTE |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:3] == 29'h0; endproperty
  a_dat: assert property (p_dat) else $error("data latch upper bits set");
  property p_rlat; ar_hs |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_wlat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  c_hold: cover property (power_mode == PM_HOLD);
  c_float: cover property (power_mode == PM_FLOAT);
  c_clk_out: cover property (pin_oe == 3'h5);
endmodule
`default_nettype wire

// *** testbench/pin_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module pin_model (
  // block side
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // far-end level on released pins
  input wire logic [2:0] ext,
  output logic [2:0] pin_in
);
  // a driven pin reads back its own level; a released one shows the far end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// *** testbench/three_bit_port_with_serial_pin_mux_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module three_bit_port_with_serial_pin_mux_tb_top;
  import port_two_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, txd = 1'b0, cko = 1'b0;
  logic bre = 1'b1, rre = 1'b1, awr, wrr, bv, arr, rv, rxd, ckin;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0, rd, rdv;
  logic [1:0] rp, rr, bp, brr;
  logic [2:0] ext = 3'h0, pin_in, pin_out, pin_oe;
  power_mode_e pm = PM_ACTIVE;
  int miscompares = 0, n_checks = 0;
  port_two dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(bp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(rre), .power_mode(pm), .ser_tx_data(txd),
    .ser_rx_data(rxd), .ser_clk_out(cko), .ser_clk_in(ckin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  initial forever #10 aclk = ~aclk;
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  // bready and rready stay high, so no task ever releases them
  task automatic reg_wr(input logic [17:0] a, input logic [7:0] d);
    bit got;
    got = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
      got = bv;
      brr = bp;
    end
  endtask
  task automatic reg_rd(input logic [17:0] a);
    bit got;
    got = 0;
    ara <= a;
    arv <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      got = rv;
      rdv = rd;
      rr = rp;
    end
  endtask
  task automatic t_reset;
    reg_rd(DATA_LATCH_BYTE);
    chk(rdv, 32'h0);
    reg_rd(DIRECTION_BYTE);
    chk(rdv, 32'hFF);
    chk(pin_oe, 3'h0);
    reg_rd(18'h1234);
    chk({rr, rdv[29:0]}, {RESP_SLVERR, 30'h0});
    reg_wr(18'h1234, 8'h07);
    chk(brr, RESP_SLVERR);
    $display("t_reset done");
  endtask
  task automatic t_gpio;
    ext <= 3'h2;
    reg_wr(DIRECTION_BYTE, 8'hFF);
    reg_wr(DATA_LATCH_BYTE, 8'hFD);
    chk(brr, RESP_OKAY);
    reg_rd(DATA_LATCH_BYTE);
    chk(rdv, 32'h5);
    chk({pin_oe, pin_out}, 6'h3D);
    $display("t_gpio done");
  endtask
  task automatic t_input;
    ext <= 3'h6;
    reg_wr(DIRECTION_BYTE, 8'h01);
    tick(6);
    reg_rd(DATA_LATCH_BYTE);
    chk(rdv, 32'h7);
    $display("t_input done");
  endtask
  task automatic t_serial;
    reg_wr(PORT_MODE_SEVEN_BYTE, 8'h04);
    reg_rd(PORT_MODE_SEVEN_BYTE);
    chk(rdv, 32'hFC);
    chk({pin_oe[PIN_TX], pin_out[PIN_TX]}, 2'h2);
    reg_wr(SERIAL_CTRL_BYTE, 8'h05);
    tick(6);
    chk({pin_oe, rxd, ckin}, 5'h12);
    txd <= 1'b1;
    ext <= 3'h7;
    tick(6);
    chk({pin_out[PIN_TX], ckin}, 2'h3);
    for (int i = 0; i < 2; i++) begin
      cko <= i[0];
      reg_wr(SERIAL_CTRL_BYTE, i ? 8'h08 : 8'h02);
      tick(2);
      chk({pin_oe, pin_out[PIN_CLK]}, {3'h5, i[0]});
    end
    reg_wr(SERIAL_CTRL_BYTE, 8'h00);
    reg_wr(PORT_MODE_SEVEN_BYTE, 8'h00);
    tick(2);
    chk({pin_oe, pin_oe & pin_out}, 6'h09);
    $display("t_serial done");
  endtask
  task automatic t_power;
    reg_wr(DIRECTION_BYTE, 8'h07);
    tick(2);
    pm <= PM_HOLD;
    reg_wr(DATA_LATCH_BYTE, 8'h02);
    tick(2);
    chk(pin_out, 3'h5);
    pm <= PM_FLOAT;
    tick(3);
    chk(pin_oe, 3'h0);
    pm <= PM_ACTIVE;
    tick(3);
    chk({pin_oe, pin_out}, 6'h3A);
    $display("t_power done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    tick(3000);
    miscompares++;
    print_verdict;
  end
  initial begin
    tick(20);
    aresetn <= 1'b1;
    t_reset;
    t_gpio;
    t_input;
    t_serial;
    t_power;
    print_verdict;
  end
endmodule
bind port_two port_two_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp,
  .power_mode, .pin_out, .pin_oe);
`default_nettype wire
